//--- core/sleep_ctl_pkg.sv
/*
 * Constants for the sleep mode control register: address, bit positions,
 * reset values, encodings and the crystal settle time.
 * Assumes a single 20 MHz system clock.
 */
package sleep_ctl_pkg;
    localparam logic [7:0] SLEEP_MODE_CONTROL_ADDR = 8'hBE;
    localparam int CAL_DIS_BIT = 7;
    localparam int XTAL_STB_BIT = 6;
    localparam int RC_STB_BIT = 5;
    localparam int CAUSE_HI_BIT = 4;
    localparam int CAUSE_LO_BIT = 3;
    localparam int PD_BIT = 2;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_LO_BIT = 0;
    localparam logic CAL_DIS_RESET = 1'b0;
    localparam logic PD_RESET = 1'b1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
    localparam logic [1:0] CAUSE_PIN = 2'h1;
    localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;
    localparam logic [1:0] POWER_LEVEL_ACTIVE = 2'h0;
    localparam logic [1:0] POWER_LEVEL_LIGHT = 2'h1;
    localparam logic [1:0] POWER_LEVEL_DEEP = 2'h2;
    localparam logic [1:0] POWER_LEVEL_OFF = 2'h3;
    localparam logic SRC_RC_OSC_A = 1'b1;
    localparam int CLOCK_HZ = 20000000;
    localparam int XTAL_SETTLE_US = 64;
    localparam int XTAL_SETTLE_CYCLES = (XTAL_SETTLE_US * (CLOCK_HZ / 1000000));
    typedef enum logic [1:0] {LEVEL_RUN, LEVEL_SLEEP} level_state_t;
endpackage

//--- core/sync_two_ff.sv
/*
 * Two flip-flop level synchroniser.
 * Assumes the input is a slowly changing level from another domain.
 */
`timescale 1ns/1ps
module sync_two_ff (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_r;
    logic stage2_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end
    assign syncOut = stage2_r;
endmodule

//--- core/sleep_mode_control_register.sv
/*
 * Sleep mode control register of the power management unit, on the SFR bus.
 * Assumes clock source select, calibration busy and the wake/reset event
 * inputs come from neighbouring logic on the same clock; the oscillator
 * stable levels come from analog and are synchronised here.
 */
`timescale 1ns/1ps
module sleep_mode_control_register
    import sleep_ctl_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic sysClkSourceSelect,
    input wire logic sleepCommitBit,
    input wire logic hfCrystalStableRaw,
    input wire logic hfRcStableRaw,
    input wire logic oscCalBusy,
    input wire logic wakeEvent,
    input wire logic resetEvent,
    input wire logic [1:0] resetCause,
    output logic rc32kCalDisableEff,
    output logic crystalPowerDown,
    output logic rcOscPowerDown,
    output logic [1:0] powerLevel,
    output logic sleepActive
);
    logic xtalStable;
    logic rcStable;
    logic calDis_r, calDis_nxt;
    logic pd_r, pd_nxt;
    logic pdPend_r, pdPend_nxt;
    logic pdPendVal_r, pdPendVal_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [1:0] cause_r, cause_nxt;
    logic [1:0] level_r, level_nxt;
    level_state_t state_r, state_nxt;
    logic hit;
    logic wakeNow;
    logic deepWake;
    logic calDisEff_r, calDisEff_nxt;
    logic xtalPd_r, xtalPd_nxt;
    logic rcPd_r, rcPd_nxt;

    sync_two_ff u_sync_xtal (
        .clock(clock),
        .sys_rst(sys_rst),
        .asyncIn(hfCrystalStableRaw),
        .syncOut(xtalStable)
    );
    sync_two_ff u_sync_rc (
        .clock(clock),
        .sys_rst(sys_rst),
        .asyncIn(hfRcStableRaw),
        .syncOut(rcStable)
    );

    assign hit = sfrWrite && (sfrAddr == SLEEP_MODE_CONTROL_ADDR);
    // a power-on reset cause wakes as well; the other causes arrive with sys_rst
    assign wakeNow = (state_r == LEVEL_SLEEP)
        && (wakeEvent || (resetEvent && resetCause == CAUSE_POWER_ON));
    assign deepWake = wakeNow && (level_r == POWER_LEVEL_DEEP || level_r == POWER_LEVEL_OFF);

    always_comb begin
        calDis_nxt = calDis_r;
        if (deepWake) begin
            // the bit is not kept in the two deepest levels
            calDis_nxt = CAL_DIS_RESET;
        end else if (hit) begin
            calDis_nxt = sfrWdata[CAL_DIS_BIT];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            calDis_r <= CAL_DIS_RESET;
        end else begin
            calDis_r <= calDis_nxt;
        end
    end

    // a power-down write during calibration is parked, not lost
    always_comb begin
        pd_nxt = pd_r;
        pdPend_nxt = pdPend_r;
        pdPendVal_nxt = pdPendVal_r;
        if (hit) begin
            if (oscCalBusy) begin
                // a second write during the same calibration replaces the parked value
                pdPend_nxt = 1'b1;
                pdPendVal_nxt = sfrWdata[PD_BIT];
            end else begin
                pd_nxt = sfrWdata[PD_BIT];
                pdPend_nxt = 1'b0;
            end
        end else if (pdPend_r && !oscCalBusy) begin
            pd_nxt = pdPendVal_r;
            pdPend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pd_r <= PD_RESET;
            pdPend_r <= 1'b0;
            pdPendVal_r <= PD_RESET;
        end else begin
            pd_r <= pd_nxt;
            pdPend_r <= pdPend_nxt;
            pdPendVal_r <= pdPendVal_nxt;
        end
    end

    always_comb begin
        cause_nxt = cause_r;
        // status bits are never taken from a write
        if (resetEvent) begin
            // a later reset simply overwrites
            cause_nxt = resetCause;
        end
    end

    // reset cause has no defined reset value; it holds across sys_rst on purpose
    always_ff @(posedge clock) begin
        cause_r <= cause_nxt;
    end

    always_comb begin
        mode_nxt = mode_r;
        level_nxt = level_r;
        state_nxt = state_r;
        if (hit) begin
            mode_nxt = sfrWdata[MODE_HI_BIT:MODE_LO_BIT];
        end
        case (state_r)
            LEVEL_RUN: begin
                // commit with the active level only idles the CPU, which is handled elsewhere
                if (sleepCommitBit && mode_r != POWER_LEVEL_ACTIVE) begin
                    level_nxt = mode_r;
                    state_nxt = LEVEL_SLEEP;
                end
            end
            LEVEL_SLEEP: begin
                if (wakeNow) begin
                    level_nxt = POWER_LEVEL_ACTIVE;
                    mode_nxt = MODE_RESET;
                    state_nxt = LEVEL_RUN;
                end
            end
            default: begin
                state_nxt = LEVEL_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= MODE_RESET;
            level_r <= POWER_LEVEL_ACTIVE;
            state_r <= LEVEL_RUN;
        end else begin
            mode_r <= mode_nxt;
            level_r <= level_nxt;
            state_r <= state_nxt;
        end
    end

    // oscillator controls are registered from the next register values, so they
    // move with the register bits; a change of clock source shows one cycle later
    always_comb begin
        calDisEff_nxt = 1'b0;
        xtalPd_nxt = 1'b0;
        rcPd_nxt = 1'b0;
        // calibration keeps running until the RC oscillator drives the system clock
        if (sysClkSourceSelect == SRC_RC_OSC_A) begin
            calDisEff_nxt = calDis_nxt;
            xtalPd_nxt = pd_nxt;
        end else begin
            rcPd_nxt = pd_nxt;
        end
    end

    // both oscillators stay up under reset: the source select is not trusted yet
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            calDisEff_r <= 1'b0;
            xtalPd_r <= 1'b0;
            rcPd_r <= 1'b0;
        end else begin
            calDisEff_r <= calDisEff_nxt;
            xtalPd_r <= xtalPd_nxt;
            rcPd_r <= rcPd_nxt;
        end
    end

    always_comb begin
        sfrRdata = 8'h00;
        if (sfrAddr == SLEEP_MODE_CONTROL_ADDR) begin
            sfrRdata[CAL_DIS_BIT] = calDis_r;
            sfrRdata[XTAL_STB_BIT] = xtalStable;
            sfrRdata[RC_STB_BIT] = rcStable;
            sfrRdata[CAUSE_HI_BIT:CAUSE_LO_BIT] = cause_r;
            sfrRdata[PD_BIT] = pd_r;
            sfrRdata[MODE_HI_BIT:MODE_LO_BIT] = mode_r;
        end
    end

    assign rc32kCalDisableEff = calDisEff_r;
    assign crystalPowerDown = xtalPd_r;
    assign rcOscPowerDown = rcPd_r;
    assign powerLevel = level_r;
    assign sleepActive = (state_r == LEVEL_SLEEP);
endmodule

//--- verif/sleep_ctl_checker.sv
/* Port checker for the sleep mode control register.
   Assumes one clock and the register address left on sfrAddr for most of the run. */
`timescale 1ns/1ps
module sleep_ctl_checker
    import sleep_ctl_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sfrWrite,
    input wire logic sysClkSourceSelect,
    input wire logic sleepCommitBit,
    input wire logic oscCalBusy,
    input wire logic wakeEvent,
    input wire logic resetEvent,
    input wire logic rc32kCalDisableEff,
    input wire logic crystalPowerDown,
    input wire logic sleepActive,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic [1:0] resetCause,
    input wire logic [1:0] powerLevel
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // fields are only visible while the register is addressed
    wire sel = sfrAddr == SLEEP_MODE_CONTROL_ADDR;
    wire wr = sfrWrite && sel;
    chk_write_fields: assert property (wr && !oscCalBusy && !wakeEvent && !resetEvent ##1 sel
        |-> {sfrRdata[7], sfrRdata[2:0]} == $past({sfrWdata[7], sfrWdata[2:0]})) else $error("write lost");
    // oscillator controls are registered, so they follow the source select of the cycle before
    chk_cal_gate: assert property (sel |-> rc32kCalDisableEff == (sfrRdata[7] && $past(sysClkSourceSelect)))
        else $error("cal gate wrong");
    chk_pd_select: assert property (sel |-> crystalPowerDown == (sfrRdata[2] && $past(sysClkSourceSelect)))
        else $error("wrong oscillator off");
    chk_pd_pending: assert property (wr && oscCalBusy ##1 oscCalBusy && sel |-> $stable(sfrRdata[2]))
        else $error("power-down changed early");
    chk_cause_last: assert property (resetEvent |=> !sel || sfrRdata[4:3] == $past(resetCause))
        else $error("reset cause lost");
    chk_status_ro: assert property (wr && !resetEvent ##1 sel |-> $stable(sfrRdata[4:3]))
        else $error("status written");
    chk_commit_enter: assert property (sleepCommitBit && sel && sfrRdata[1:0] != 2'h0 && !wakeEvent && !resetEvent
        |=> sleepActive && powerLevel == $past(sfrRdata[1:0])) else $error("mode not entered");
    chk_wake_clear: assert property (wakeEvent && !sfrWrite |=> !sleepActive && powerLevel == 2'h0)
        else $error("no wake");
    cover property (sleepActive ##1 !sleepActive);
    cover property (wr && oscCalBusy);
    cover property (resetEvent ##1 resetEvent);
endmodule
bind sleep_mode_control_register sleep_ctl_checker chk (.*);

//--- verif/sleep_mode_control_register_tb.sv
/* Self-checking bench for the sleep mode control register.
   Drives every input itself, 5 ns after each rising clock edge. */
`timescale 1ns/1ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t got %h", $time, a); end end
module sleep_mode_control_register_tb;
    logic clock = 0, sys_rst = 1, sfrWrite = 0, sysClkSourceSelect = 0, sleepCommitBit = 0, hfCrystalStableRaw = 0;
    logic hfRcStableRaw = 0, oscCalBusy = 0, wakeEvent = 0, resetEvent = 0;
    logic rc32kCalDisableEff, crystalPowerDown, rcOscPowerDown, sleepActive;
    logic [7:0] sfrAddr = 8'hBE, sfrWdata = 8'h00, sfrRdata;
    logic [1:0] resetCause = 2'h0, powerLevel;
    int failures = 0, nCompared = 0;
    always #25 clock = ~clock;
    sleep_mode_control_register uut (.*);
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task automatic wr(logic [7:0] d);
        sfrWrite = 1;
        sfrWdata = d;
        tick();
        sfrWrite = 0;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
        tick();
    endtask
    task automatic test_done;
        if (failures == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        tick(12);
        sys_rst = 0;
        `CHK(sfrRdata & 8'hE7, 8'h04)
        for (int c = 0; c < 3; c++) begin
            resetCause = 2'(c);
            pulse(resetEvent);
            `CHK(sfrRdata[4:3], resetCause)
        end
        resetEvent = 1;
        resetCause = 2'h1;
        tick();
        resetCause = 2'h2;
        tick();
        resetEvent = 0;
        `CHK(sfrRdata[4:3], 2'h2)
        wr(8'h78);
        `CHK(sfrRdata, 8'h10)
        hfCrystalStableRaw = 1;
        hfRcStableRaw = 1;
        tick(3);
        `CHK(sfrRdata[6:5], 2'h3)
        // software lets the crystal settle before it may be chosen as source
        tick(sleep_ctl_pkg::XTAL_SETTLE_CYCLES);
        wr(8'h04);
        sysClkSourceSelect = 1;
        tick();
        `CHK({crystalPowerDown, rcOscPowerDown}, 2'h2)
        sysClkSourceSelect = 0;
        wr(8'h80);
        `CHK({crystalPowerDown, rcOscPowerDown, rc32kCalDisableEff, sfrRdata[7]}, 4'h1)
        sysClkSourceSelect = 1;
        tick();
        `CHK(rc32kCalDisableEff, 1'b1)
        // the write lands while calibration runs, so it must wait
        oscCalBusy = 1;
        wr(8'h84);
        tick(2);
        `CHK(sfrRdata[2], 1'b0)
        oscCalBusy = 0;
        tick();
        `CHK(sfrRdata[2], 1'b1)
        for (int m = 1; m < 4; m++) begin
            wr(8'h80 | 8'(m));
            pulse(sleepCommitBit);
            `CHK({sleepActive, powerLevel}, {1'b1, 2'(m)})
            pulse(wakeEvent);
            `CHK({sleepActive, powerLevel, sfrRdata[7], sfrRdata[1:0]}, {3'h0, m < 2, 2'h0})
        end
        wr(8'h03);
        pulse(sleepCommitBit);
        resetCause = 2'h0;
        pulse(resetEvent);
        `CHK({sleepActive, powerLevel, sfrRdata[1:0]}, 5'h00)
        sfrAddr = 8'h87;
        wr(8'h03);
        `CHK(sfrRdata, 8'h00)
        sfrAddr = 8'hBE;
        `CHK(sfrRdata[1:0], 2'h0)
        test_done();
    end
endmodule
